// ===== cidp_params.svh
// Constants for the caller identification message parser
`ifndef CIDP_PARAMS_SVH
`define CIDP_PARAMS_SVH

// ************************************************************
// Message framing words
// ************************************************************
`define CIDP_TYPE_SINGLE   8'h04
`define CIDP_TYPE_MULTI    8'h80

// ************************************************************
// Parameter kind words of the multiple-data format
// ************************************************************
`define CIDP_PARM_TIME     8'h01
`define CIDP_PARM_NUMBER   8'h02
`define CIDP_PARM_NAME     8'h07
`define CIDP_PARM_CODE     8'h04

// ************************************************************
// Sizes
// ************************************************************
`define CIDP_WORD_W        8
`define CIDP_TIME_LEN      4
`define CIDP_FIELD_DEPTH   32
`define CIDP_FIFO_DEPTH    16

`endif

// ===== cidp_pkg.sv
// Types shared by the caller identification message parser
package cidp_pkg;

  typedef enum logic [1:0] {
    CIDP_FMT_NONE,
    CIDP_FMT_SINGLE,
    CIDP_FMT_MULTI
  } cidp_fmt_t;

  typedef enum logic [1:0] {
    CIDP_FLD_TIME,
    CIDP_FLD_NUMBER,
    CIDP_FLD_NAME,
    CIDP_FLD_CODE
  } cidp_field_t;

endpackage

// ===== cidp_fifo.sv
// Word FIFO between the demodulator and the parser
`timescale 1ns/1ns
module cidp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             flush_in
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("cidp_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  wire              full_w  = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire              empty_w = (wr_ptr_r == rd_ptr_r);
  wire              push_w  = in_valid_in && !full_w;
  wire              pop_w   = out_ready_in && !empty_w;

  assign in_ready_out  = !full_w;
  assign out_valid_out = !empty_w;
  assign out_data_out  = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk_in) begin
    if (push_w) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || flush_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push_w) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop_w)  rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule // cidp_fifo

// ===== cidp_field_mem.sv
// Small memory holding the captured number and name characters
`timescale 1ns/1ns
module cidp_field_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic                     clk_in,
  input  wire logic                     wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic      [WIDTH-1:0]         rd_data_out
);
  initial begin
    if (DEPTH < 2) $error("cidp_field_mem: DEPTH must be at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) mem_r[wr_addr_in] <= wr_data_in;
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule // cidp_field_mem

// ===== cidp_parser.sv
// Caller identification message parser: framing, field capture and display select
//
// What this block does
// - Tone-keyed messages are taken only in the gap after the first ring ends and before the second starts.
// - Every type, length and payload element is handled as one whole 8-bit word.
// - A first word of 00000100 marks the single-data format.
// - In single-data format the word after the type gives the payload count, and exactly that many are consumed.
// - Single-data payload is month, day, hour and minute, then the calling number.
// - A first word of 10000000 marks the multiple-data format.
// - In multiple-data format the word after the type gives the total parameter-word count that ends the message.
// - Each multiple-data parameter opens with a kind word naming what follows.
// - After the kind word comes a value count, and exactly that many value words are taken before the next kind.
// - Caller name and data code parameters are captured besides time and number.
// - After a multiple-data message the name, or else the number, is offered for display.
// - In DTMF mode identification words are accepted before any ring has been seen.
`timescale 1ns/1ns
`include "cidp_params.svh"
module cidp_parser
  import cidp_pkg::*;
#(
  parameter int FIFO_DEPTH  = `CIDP_FIFO_DEPTH,
  parameter int FIELD_DEPTH = `CIDP_FIELD_DEPTH
) (
  input  wire logic                           clk_in,
  input  wire logic                           srst_in,
  input  wire logic                           ring_in,
  input  wire logic                           dtmf_mode_in,
  input  wire logic                           word_valid_in,
  output logic                                word_ready_out,
  input  wire logic [7:0]                     word_data_in,
  output cidp_pkg::cidp_fmt_t                 fmt_out,
  output logic                                done_out,
  output logic                                abort_out,
  output logic [7:0]                          month_out,
  output logic [7:0]                          day_out,
  output logic [7:0]                          hour_out,
  output logic [7:0]                          minute_out,
  output logic [7:0]                          code_out,
  output logic                                show_name_out,
  output logic [$clog2(FIELD_DEPTH):0]        show_len_out,
  input  wire logic [$clog2(FIELD_DEPTH)-1:0] show_addr_in,
  output logic [7:0]                          show_data_out
);
  import cidp_pkg::*;

  localparam int FA = $clog2(FIELD_DEPTH);

  initial begin
    if (FIELD_DEPTH < 2 || FIELD_DEPTH > 128) $error("cidp_parser: FIELD_DEPTH out of range");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [2:0] {
    CIDP_ST_IDLE,
    CIDP_ST_MSG_LEN,
    CIDP_ST_DATA,
    CIDP_ST_PARM_KIND,
    CIDP_ST_PARM_LEN,
    CIDP_ST_PARM_DATA
  } cidp_state_t;

  cidp_state_t         state_r;
  cidp_state_t         state_nxt;
  cidp_fmt_t           fmt_r;
  cidp_field_t         field_r;
  logic [7:0]          msg_cnt_r;
  logic [7:0]          parm_cnt_r;
  logic [7:0]          idx_r;
  logic                ring_d_r;
  logic [1:0]          rings_r;
  logic [FA:0]         num_len_r;
  logic [FA:0]         name_len_r;
  logic                done_r;
  logic                abort_r;
  logic [7:0]          month_r;
  logic [7:0]          day_r;
  logic [7:0]          hour_r;
  logic [7:0]          minute_r;
  logic [7:0]          code_r;

  // ************************************************************
  // Input buffering
  // ************************************************************
  wire       fifo_flush_w;
  wire       fv_w;
  wire [7:0] fd_w;
  wire       take_w;

  cidp_fifo #(
    .WIDTH (`CIDP_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .in_valid_in   (word_valid_in),
    .in_ready_out  (word_ready_out),
    .in_data_in    (word_data_in),
    .out_valid_out (fv_w),
    .out_ready_in  (take_w),
    .out_data_out  (fd_w),
    .flush_in      (fifo_flush_w)
  );

  // ************************************************************
  // Ring tracking and the listening window
  // ************************************************************
  wire ring_end_w   = ring_d_r && !ring_in;
  wire ring_start_w = ring_in && !ring_d_r;
  // FSK listens between first and second ring; DTMF listens before any ring
  wire listen_w     = dtmf_mode_in ? (rings_r == 2'd0 && !ring_in)
                                   : (rings_r == 2'd1 && !ring_in);
  // Any ring start kills an unfinished message (the second ring in FSK mode, the first ring in DTMF mode)
  wire ring_kill_w  = ring_start_w && (state_r != CIDP_ST_IDLE);
  // Words outside the window are drained and thrown away, so the FIFO never clogs
  assign take_w       = fv_w;
  assign fifo_flush_w = ring_kill_w;
  wire word_w       = fv_w && listen_w && !ring_kill_w;

  wire is_single_w  = (fd_w == `CIDP_TYPE_SINGLE);
  wire is_multi_w   = (fd_w == `CIDP_TYPE_MULTI);
  wire msg_last_w   = (msg_cnt_r == 8'd1);
  wire parm_last_w  = (parm_cnt_r == 8'd1);

  function automatic cidp_field_t kind_to_field(input logic [7:0] k);
    unique case (k)
      `CIDP_PARM_TIME:   kind_to_field = CIDP_FLD_TIME;
      `CIDP_PARM_NUMBER: kind_to_field = CIDP_FLD_NUMBER;
      `CIDP_PARM_NAME:   kind_to_field = CIDP_FLD_NAME;
      default:           kind_to_field = CIDP_FLD_CODE;
    endcase
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    if (ring_kill_w) begin
      state_nxt = CIDP_ST_IDLE;
    end else if (word_w) begin
      unique case (state_r)
        CIDP_ST_IDLE:      state_nxt = (is_single_w || is_multi_w) ? CIDP_ST_MSG_LEN : CIDP_ST_IDLE;
        CIDP_ST_MSG_LEN:   state_nxt = (fd_w == 8'h00) ? CIDP_ST_IDLE :
                                       (fmt_r == CIDP_FMT_SINGLE) ? CIDP_ST_DATA : CIDP_ST_PARM_KIND;
        CIDP_ST_DATA:      state_nxt = msg_last_w ? CIDP_ST_IDLE : CIDP_ST_DATA;
        CIDP_ST_PARM_KIND: state_nxt = msg_last_w ? CIDP_ST_IDLE : CIDP_ST_PARM_LEN;
        CIDP_ST_PARM_LEN:  state_nxt = msg_last_w ? CIDP_ST_IDLE :
                                       (fd_w == 8'h00) ? CIDP_ST_PARM_KIND : CIDP_ST_PARM_DATA;
        CIDP_ST_PARM_DATA: state_nxt = msg_last_w ? CIDP_ST_IDLE :
                                       parm_last_w ? CIDP_ST_PARM_KIND : CIDP_ST_PARM_DATA;
        default:           state_nxt = CIDP_ST_IDLE;
      endcase
    end
  end

  // A parameter cut short by the message count is a framing error
  wire parm_short_w = word_w && msg_last_w &&
                      ((state_r == CIDP_ST_PARM_KIND) || (state_r == CIDP_ST_PARM_LEN) ||
                       (state_r == CIDP_ST_PARM_DATA && !parm_last_w));
  wire finish_w     = word_w && msg_last_w && !parm_short_w &&
                      ((state_r == CIDP_ST_DATA) || (state_r == CIDP_ST_PARM_DATA));
  wire bad_type_w   = word_w && (state_r == CIDP_ST_IDLE) && !is_single_w && !is_multi_w;

  // ************************************************************
  // Capture targets
  // ************************************************************
  wire       in_data_w   = word_w && ((state_r == CIDP_ST_DATA) || (state_r == CIDP_ST_PARM_DATA));
  wire       time_slot_w = (state_r == CIDP_ST_DATA) ? (idx_r < `CIDP_TIME_LEN)
                                                     : (field_r == CIDP_FLD_TIME);
  wire       num_slot_w  = (state_r == CIDP_ST_DATA) ? !time_slot_w : (field_r == CIDP_FLD_NUMBER);
  wire       name_slot_w = (state_r == CIDP_ST_PARM_DATA) && (field_r == CIDP_FLD_NAME);
  wire [7:0] chr_idx_w   = (state_r == CIDP_ST_DATA) ? idx_r - 8'(`CIDP_TIME_LEN) : idx_r;
  wire       chr_fit_w   = (chr_idx_w < 8'(FIELD_DEPTH));
  wire       num_wr_w    = in_data_w && num_slot_w && chr_fit_w;
  wire       name_wr_w   = in_data_w && name_slot_w && chr_fit_w;

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_r  <= CIDP_ST_IDLE;
      ring_d_r <= 1'b0;
      rings_r  <= 2'd0;
    end else begin
      state_r  <= state_nxt;
      ring_d_r <= ring_in;
      // Ring count saturates at 3; a completed message sets it to 3, where it stays until reset
      if (ring_end_w && rings_r != 2'd3) rings_r <= rings_r + 2'd1;
      else if (finish_w)                 rings_r <= 2'd3;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fmt_r      <= CIDP_FMT_NONE;
      field_r    <= CIDP_FLD_TIME;
      msg_cnt_r  <= 8'h00;
      parm_cnt_r <= 8'h00;
      idx_r      <= 8'h00;
    end else if (word_w) begin
      if (state_r == CIDP_ST_IDLE) begin
        fmt_r <= is_single_w ? CIDP_FMT_SINGLE : (is_multi_w ? CIDP_FMT_MULTI : CIDP_FMT_NONE);
      end
      if (state_r == CIDP_ST_MSG_LEN) msg_cnt_r <= fd_w;
      else if (state_r != CIDP_ST_IDLE) msg_cnt_r <= msg_cnt_r - 8'd1;
      if (state_r == CIDP_ST_PARM_KIND) field_r <= kind_to_field(fd_w);
      if (state_r == CIDP_ST_PARM_LEN) parm_cnt_r <= fd_w;
      else if (state_r == CIDP_ST_PARM_DATA) parm_cnt_r <= parm_cnt_r - 8'd1;
      if (state_r == CIDP_ST_MSG_LEN || state_r == CIDP_ST_PARM_LEN) idx_r <= 8'h00;
      else if (in_data_w) idx_r <= idx_r + 8'd1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      month_r    <= 8'h00;
      day_r      <= 8'h00;
      hour_r     <= 8'h00;
      minute_r   <= 8'h00;
      code_r     <= 8'h00;
      num_len_r  <= '0;
      name_len_r <= '0;
    end else begin
      if (word_w && state_r == CIDP_ST_MSG_LEN) begin
        num_len_r  <= '0;
        name_len_r <= '0;
      end
      if (in_data_w && time_slot_w) begin
        unique case (idx_r[1:0])
          2'd0: month_r  <= fd_w;
          2'd1: day_r    <= fd_w;
          2'd2: hour_r   <= fd_w;
          2'd3: minute_r <= fd_w;
        endcase
      end
      if (in_data_w && state_r == CIDP_ST_PARM_DATA && field_r == CIDP_FLD_CODE) code_r <= fd_w;
      if (num_wr_w)  num_len_r  <= chr_idx_w[FA:0] + 1'b1;
      if (name_wr_w) name_len_r <= chr_idx_w[FA:0] + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      done_r  <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      done_r  <= finish_w;
      abort_r <= ring_kill_w || bad_type_w || parm_short_w;
    end
  end

  // ************************************************************
  // Field stores and display select
  // ************************************************************
  wire [7:0] num_rd_w;
  wire [7:0] name_rd_w;
  // Name wins when a multiple-data message carried one; otherwise the number
  wire       show_name_w = (fmt_r == CIDP_FMT_MULTI) && (name_len_r != '0);

  cidp_field_mem #(
    .WIDTH (`CIDP_WORD_W),
    .DEPTH (FIELD_DEPTH)
  ) u_num_mem (
    .clk_in      (clk_in),
    .wr_en_in    (num_wr_w),
    .wr_addr_in  (chr_idx_w[FA-1:0]),
    .wr_data_in  (fd_w),
    .rd_addr_in  (show_addr_in),
    .rd_data_out (num_rd_w)
  );

  cidp_field_mem #(
    .WIDTH (`CIDP_WORD_W),
    .DEPTH (FIELD_DEPTH)
  ) u_name_mem (
    .clk_in      (clk_in),
    .wr_en_in    (name_wr_w),
    .wr_addr_in  (chr_idx_w[FA-1:0]),
    .wr_data_in  (fd_w),
    .rd_addr_in  (show_addr_in),
    .rd_data_out (name_rd_w)
  );

  assign fmt_out       = fmt_r;
  assign done_out      = done_r;
  assign abort_out     = abort_r;
  assign month_out     = month_r;
  assign day_out       = day_r;
  assign hour_out      = hour_r;
  assign minute_out    = minute_r;
  assign code_out      = code_r;
  assign show_name_out = show_name_w;
  assign show_len_out  = show_name_w ? name_len_r : num_len_r;
  assign show_data_out = show_name_w ? name_rd_w : num_rd_w;
endmodule // cidp_parser

// ===== cidp_parser_monitor.sv
// Port checker for the caller identification message parser
`timescale 1ns/1ns
module cidp_parser_monitor
  import cidp_pkg::*;
#(
  parameter int FIFO_DEPTH  = 16,
  parameter int FIELD_DEPTH = 32
) (
  input wire logic                    clk_in,
  input wire logic                    srst_in,
  input wire logic                    ring_in,
  input wire logic                    word_valid_in,
  input wire logic                    word_ready_out,
  input wire cidp_pkg::cidp_fmt_t     fmt_out,
  input wire logic                    done_out,
  input wire logic                    abort_out,
  input wire logic                    show_name_out,
  input wire logic [$clog2(FIELD_DEPTH):0] show_len_out
);
  logic [15:0] n_push_r;
  logic [15:0] n_done_r;

  // Every finished message took at least type, length and one more word
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      n_push_r <= 16'h0000;
      n_done_r <= 16'h0000;
    end else begin
      n_push_r <= n_push_r + {15'h0000, word_valid_in & word_ready_out};
      n_done_r <= n_done_r + {15'h0000, done_out};
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_done_pulse: assert property (done_out |=> !done_out)
    else $error("done held longer than one cycle");
  a_abort_pulse: assert property (abort_out |=> !abort_out)
    else $error("abort held longer than one cycle");
  a_done_abort_excl: assert property (!(done_out && abort_out))
    else $error("done and abort together");
  a_ready_reset: assert property ($fell(srst_in) |-> word_ready_out && fmt_out == CIDP_FMT_NONE)
    else $error("not empty and idle after reset");
  a_done_words: assert property (done_out |-> 32'(n_push_r) >= 3 * 32'(n_done_r) + 3)
    else $error("message done with too few words");
  a_ring_quiet: assert property (ring_in [*4] |-> !done_out && $stable(fmt_out))
    else $error("message taken during ring burst");
  a_name_multi: assert property (show_name_out |-> fmt_out == CIDP_FMT_MULTI)
    else $error("name shown outside multiple format");
  a_done_fmt: assert property (done_out |-> fmt_out inside {CIDP_FMT_SINGLE, CIDP_FMT_MULTI})
    else $error("done without known format");
  a_len_bound: assert property (show_len_out <= FIELD_DEPTH)
    else $error("shown length beyond field memory");
  a_ready_refuse: assert property (!word_ready_out |-> 32'(n_push_r) >= FIFO_DEPTH)
    else $error("buffer refused before it could be full");
endmodule // cidp_parser_monitor

bind cidp_parser cidp_parser_monitor #(.FIFO_DEPTH(FIFO_DEPTH), .FIELD_DEPTH(FIELD_DEPTH)) cidp_parser_monitor_i (
  .clk_in(clk_in), .srst_in(srst_in), .ring_in(ring_in), .word_valid_in(word_valid_in),
  .word_ready_out(word_ready_out), .fmt_out(fmt_out), .done_out(done_out), .abort_out(abort_out),
  .show_name_out(show_name_out), .show_len_out(show_len_out));

// ===== cidp_exchange_model.sv
// Exchange side model handing demodulated caller words to the parser
`timescale 1ns/1ns
module cidp_exchange_model (
  input  wire logic       clk_in,
  input  wire logic       ready_in,
  output logic            valid_out,
  output logic [7:0]      data_out
);
  initial begin
    valid_out = 1'b0;
    data_out  = 8'h5a;
  end

  // Tone bits arrive already gathered into whole words
  task automatic send(input logic [7:0] w, input int gap);
    valid_out = 1'b1;
    data_out  = w;
    do @(posedge clk_in); while (ready_in !== 1'b1);
    @(negedge clk_in);
    if (gap > 0) begin
      stop();
      repeat (gap) @(negedge clk_in);
    end
  endtask

  // Released line shows the inverse so a stale word never looks held
  task automatic stop;
    valid_out = 1'b0;
    data_out  = ~data_out;
  endtask
endmodule // cidp_exchange_model

// ===== tb_top.sv
// Self-checking bench for the caller identification message parser
`timescale 1ns/1ns
module tb_top;
  import cidp_pkg::*;
  typedef struct {
    logic ring; logic dtmf; logic slow; int n; logic [143:0] b;
    logic done; logic ab; cidp_fmt_t fmt; logic [31:0] tim;
    logic name; logic [5:0] len; logic [7:0] ch0; logic [7:0] code;
  } cidp_row_t;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        ring_in = 1'b0;
  logic        dtmf_mode_in = 1'b0;
  logic        word_valid_in;
  logic        word_ready_out;
  logic [7:0]  word_data_in;
  cidp_fmt_t   fmt_out;
  logic        done_out, abort_out, show_name_out;
  logic [7:0]  month_out, day_out, hour_out, minute_out, code_out, show_data_out;
  logic [5:0]  show_len_out;
  logic [4:0]  show_addr_in = 5'h00;
  int          failures = 0;
  int          n_checks = 0;
  logic        d, a;
  cidp_row_t   r;
  cidp_row_t   rows [9] = '{
    '{1,0,0,8,144'h0406010203043132,1,0,CIDP_FMT_SINGLE,32'h01020304,0,6'h02,8'h31,8'h00},
    '{1,0,1,18,144'h80100104050607080201350702414209015a,1,0,CIDP_FMT_MULTI,32'h05060708,1,6'h02,8'h41,8'h5a},
    '{0,1,0,7,144'h0405_0a0b0c0d39,1,0,CIDP_FMT_SINGLE,32'h0a0b0c0d,0,6'h01,8'h39,8'h00},
    '{1,0,0,5,144'h8003020137,1,0,CIDP_FMT_MULTI,32'h00000000,0,6'h01,8'h37,8'h00},
    '{1,0,0,1,144'h33,0,1,CIDP_FMT_NONE,32'h0,0,6'h00,8'h00,8'h00},
    '{1,0,0,5,144'h8003020531,0,1,CIDP_FMT_MULTI,32'h0,0,6'h00,8'h00,8'h00},
    '{0,0,0,8,144'h0406010203043132,0,0,CIDP_FMT_NONE,32'h0,0,6'h00,8'h00,8'h00},
    '{1,1,0,7,144'h04050a0b0c0d39,0,0,CIDP_FMT_NONE,32'h0,0,6'h00,8'h00,8'h00},
    '{1,0,0,2,144'h0400,0,0,CIDP_FMT_NONE,32'h0,0,6'h00,8'h00,8'h00}};

  always #50 clk_in = ~clk_in;

  cidp_parser cidp_parser_i (.clk_in(clk_in), .srst_in(srst_in), .ring_in(ring_in), .dtmf_mode_in(dtmf_mode_in),
    .word_valid_in(word_valid_in), .word_ready_out(word_ready_out), .word_data_in(word_data_in),
    .fmt_out(fmt_out), .done_out(done_out), .abort_out(abort_out), .month_out(month_out), .day_out(day_out),
    .hour_out(hour_out), .minute_out(minute_out), .code_out(code_out), .show_name_out(show_name_out),
    .show_len_out(show_len_out), .show_addr_in(show_addr_in), .show_data_out(show_data_out));
  cidp_exchange_model cidp_exchange_model_i (.clk_in(clk_in), .ready_in(word_ready_out),
    .valid_out(word_valid_in), .data_out(word_data_in));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkf(input cidp_fmt_t e);
    n_checks++;
    if (fmt_out !== e) begin
      failures++;
      $display("Error fmt expected %0d seen %0d", e, fmt_out);
    end
  endtask
  task automatic do_reset;
    @(negedge clk_in);
    srst_in = 1'b1;
    ring_in = 1'b0;
    repeat (4) @(negedge clk_in);
    srst_in = 1'b0;
  endtask
  // Ring burst, then the silent gap that opens the window in FSK mode (in DTMF mode the ring closes it)
  task automatic first_ring;
    ring_in = 1'b1;
    repeat (5) @(negedge clk_in);
    ring_in = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask
  task automatic watch;
    d = 1'b0;
    a = 1'b0;
    repeat (40) begin
      @(posedge clk_in);
      #1;
      if (done_out === 1'b1) d = 1'b1;
      if (abort_out === 1'b1) a = 1'b1;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #500000;
    failures++;
    end_sim();
  end

  // ************************************************************
  // Message table, then reset and mid-message ring
  // ************************************************************
  initial begin
    for (int i = 0; i < 9; i++) begin
      r = rows[i];
      do_reset();
      dtmf_mode_in = r.dtmf;
      if (r.ring) first_ring();
      for (int k = 0; k < r.n; k++) cidp_exchange_model_i.send(r.b[8*(r.n-1-k) +: 8], int'(r.slow && k % 3 == 0));
      cidp_exchange_model_i.stop();
      watch();
      chk("done", 32'(r.done), 32'(d));
      chk("abort", 32'(r.ab), 32'(a));
      if (r.done) begin
        chkf(r.fmt);
        chk("time", r.tim, {month_out, day_out, hour_out, minute_out});
        chk("name", 32'(r.name), 32'(show_name_out));
        chk("len", 32'(r.len), 32'(show_len_out));
        chk("code", 32'(r.code), 32'(code_out));
        @(negedge clk_in);
        show_addr_in = 5'h00;
        @(posedge clk_in);
        #1;
        chk("char", 32'(r.ch0), 32'(show_data_out));
      end
      $display("row %0d finished", i);
    end
    do_reset();
    @(posedge clk_in);
    #1;
    chkf(CIDP_FMT_NONE);
    chk("idle", 32'h9, {28'h0, word_ready_out, done_out, abort_out, show_len_out == 6'h00});
    $display("reset test finished");
    do_reset();
    dtmf_mode_in = 1'b0;
    first_ring();
    for (int k = 0; k < 4; k++) cidp_exchange_model_i.send(8'(32'h04060102 >> (24 - 8 * k)), 0);
    cidp_exchange_model_i.stop();
    ring_in = 1'b1;
    watch();
    chk("ring done", 32'h0, 32'(d));
    chk("ring abort", 32'h1, 32'(a));
    $display("mid message ring test finished");
    end_sim();
  end
endmodule // tb_top
